/* shared/spo_pkg.sv */
package spo_pkg;
    // =====================================================
    // SPE geometry
    localparam logic [3:0] SPE_ROWS = 4'h9;
    localparam logic [8:0] SPE_COLS = 9'h105;
    localparam logic [3:0] ROW_J1 = 4'h0;
    localparam logic [3:0] ROW_B3 = 4'h1;
    localparam logic [3:0] ROW_C2 = 4'h2;
    localparam logic [3:0] ROW_G1 = 4'h3;
    localparam logic [3:0] ROW_F2 = 4'h4;
    localparam logic [3:0] ROW_H4 = 4'h5;
    localparam logic [3:0] ROW_Z3 = 4'h6;
    localparam logic [3:0] ROW_Z4 = 4'h7;
    // =====================================================
    // register map (byte addresses)
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_CMD = 12'h004;
    localparam logic [11:0] OFS_B3MASK = 12'h008;
    localparam logic [11:0] OFS_POH_A = 12'h00c;
    localparam logic [11:0] OFS_POH_B = 12'h010;
    localparam logic [11:0] OFS_STATUS = 12'h014;
    localparam logic [11:0] OFS_TRACE = 12'h100;
    // control register fields
    localparam int CTRL_AIS = 0;
    localparam int CTRL_ATM = 1;
    localparam int CTRL_TLEN = 2;
    localparam int CTRL_RDI_AUTO = 4;
    localparam int CTRL_RDI_SW = 5;
    localparam int CTRL_REI_AUTO = 6;
    localparam int CTRL_REI_SW = 7;
    localparam int CTRL_NDF_CONT = 8;
    localparam logic [8:0] CTRL_RESET = 9'h053;
    // command register fields (write one to fire)
    localparam int CMD_INC = 0;
    localparam int CMD_DEC = 1;
    localparam int CMD_NDF = 2;
    // trace length codes
    localparam logic [1:0] TLEN_1 = 2'h0;
    localparam logic [1:0] TLEN_16 = 2'h1;
    // fill bytes when the source has nothing ready
    localparam logic [7:0] FILL_ATM = 8'h00;
    localparam logic [7:0] FILL_PKT = 8'h7e;
    localparam logic [3:0] REI_MAX = 4'h8;
    localparam logic [7:0] ALL_ONES = 8'hff;

    typedef struct packed {
        logic valid;
        logic poh;
        logic first;
        logic [7:0] data;
    } spo_spe_out_t;

    typedef struct packed {
        logic ais;
        logic inc;
        logic dec;
        logic ndf;
    } spo_ptr_ctl_t;

    typedef struct packed {
        logic ais;
        logic lop;
        logic uneq;
        logic tim;
        logic plm;
        logic lcd;
    } spo_defects_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic [8:0] ctrl;
        logic [7:0] b3_mask;
        logic [7:0] c2;
        logic [7:0] f2;
        logic [7:0] h4;
        logic [7:0] z3;
        logic [7:0] z4;
        logic [7:0] z5;
        logic [2:0] g1_spare;
        logic [63:0][7:0] trace;
        logic [5:0] trace_idx;
        logic inc_pend;
        logic dec_pend;
        logic ndf_pend;
        logic [3:0] row;
        logic [8:0] col;
        logic [7:0] bip_acc;
        logic [7:0] b3_hold;
        logic [3:0] rei_acc;
        logic [1:0][7:0] hold;
        logic [1:0] hold_cnt;
        logic cell_ready;
        logic pkt_ready;
        logic rdi_tx;
        spo_spe_out_t out;
        spo_ptr_ctl_t ptr;
    } spo_state_t;
endpackage

/* rtl/spo_path_overhead_tx.sv */
`timescale 1ns/1ps
// Function
// - in ATM mode, cell bytes fill the SPE payload positions
// - in packet mode, packet bytes fill the SPE payload positions
// - compute path BIP-8 over generated SPE bytes, send in B3
// - software can corrupt the transmitted B3 for testing
// - supply J1, C2, G1, F2, H4, Z3, Z4, Z5 in every SPE
// - auto RDI while receive path reports AIS, LOP, UNEQ, TIM or PLM
// - auto RDI while receive cell side reports loss of cell delineation
// - software can command RDI regardless of receive defects
// - auto REI from B3 errors counted on the receive side
// - software can command REI
// - path AIS is sent from reset, then only on software command
// - path trace of 1, 16 or 64 bytes in successive J1 bytes
// - forced positive and negative pointer stuffs on command
// - single or continuous new data flag events on command
// - assembled SPE bytes go to the transport overhead processor
// - SPE is nine rows of 261 byte columns
// - B3 of one SPE is sent in the next SPE
// - outgoing B3 is XORed with an 8-bit mask, zero means clean
// - during AIS all SPE and H1-H3 bytes are ones, no traffic taken
// - first column carries the nine overhead bytes, rest payload
module spo_path_overhead_tx (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cell_valid,
    input wire logic [7:0] cell_data,
    output logic cell_ready,
    input wire logic pkt_valid,
    input wire logic [7:0] pkt_data,
    output logic pkt_ready,
    input wire spo_pkg::spo_defects_t rx_defects,
    input wire logic rx_b3_err_vld,
    input wire logic [3:0] rx_b3_err_cnt,
    input wire logic spe_req,
    output spo_pkg::spo_spe_out_t spe_out,
    output spo_pkg::spo_ptr_ctl_t ptr_ctl
);
    spo_pkg::spo_state_t st_reg;
    spo_pkg::spo_state_t st_next;

    logic ais;
    logic atm;
    logic apb_wr;
    logic pop;
    logic push;
    logic [7:0] src_data;
    logic [7:0] byte_out;
    logic [1:0] cnt_after_pop;
    logic [3:0] rei_sum;
    logic [3:0] rei_field;
    logic [4:0] rei_wide;
    logic last_byte;
    logic [5:0] trace_wrap;
    logic rdi_auto;

    always_comb begin
        st_next = st_reg;
        ais = st_reg.ctrl[spo_pkg::CTRL_AIS];
        atm = st_reg.ctrl[spo_pkg::CTRL_ATM];
        // =====================================================
        // apb slave: one wait state, answer in the second access cycle
        apb_wr = psel && penable && st_reg.pready && pwrite;
        st_next.pready = psel && penable && !st_reg.pready;
        st_next.pslverr = 1'b0;
        if (psel && penable && !st_reg.pready) begin
            st_next.prdata = 32'h0;
            if (paddr[11:8] == spo_pkg::OFS_TRACE[11:8]) begin
                st_next.prdata = {24'h0, st_reg.trace[paddr[7:2]]};
            end else begin
                unique case (paddr)
                    spo_pkg::OFS_CTRL: st_next.prdata = {23'h0, st_reg.ctrl};
                    spo_pkg::OFS_CMD: st_next.prdata = 32'h0;
                    spo_pkg::OFS_B3MASK: st_next.prdata = {24'h0, st_reg.b3_mask};
                    spo_pkg::OFS_POH_A:
                        st_next.prdata = {st_reg.z3, st_reg.h4, st_reg.f2, st_reg.c2};
                    spo_pkg::OFS_POH_B:
                        st_next.prdata = {13'h0, st_reg.g1_spare, st_reg.z5, st_reg.z4};
                    spo_pkg::OFS_STATUS:
                        st_next.prdata = {16'h0, st_reg.b3_hold, 5'h0, st_reg.hold_cnt,
                                          st_reg.rdi_tx};
                    default: st_next.pslverr = 1'b1;
                endcase
            end
        end
        if (apb_wr && paddr[11:8] == spo_pkg::OFS_TRACE[11:8]) begin
            st_next.trace[paddr[7:2]] = pwdata[7:0];
        end else if (apb_wr) begin
            unique case (paddr)
                spo_pkg::OFS_CTRL: st_next.ctrl = pwdata[8:0];
                spo_pkg::OFS_B3MASK: st_next.b3_mask = pwdata[7:0];
                spo_pkg::OFS_POH_A: begin
                    st_next.c2 = pwdata[7:0];
                    st_next.f2 = pwdata[15:8];
                    st_next.h4 = pwdata[23:16];
                    st_next.z3 = pwdata[31:24];
                end
                spo_pkg::OFS_POH_B: begin
                    st_next.z4 = pwdata[7:0];
                    st_next.z5 = pwdata[15:8];
                    st_next.g1_spare = pwdata[18:16];
                end
                default: begin
                end
            endcase
        end
        // =====================================================
        // RDI: any enabled defect or the software bit holds it on
        rdi_auto = st_reg.ctrl[spo_pkg::CTRL_RDI_AUTO] &&
                   (rx_defects.ais || rx_defects.lop || rx_defects.uneq ||
                    rx_defects.tim || rx_defects.plm || rx_defects.lcd);
        st_next.rdi_tx = rdi_auto || st_reg.ctrl[spo_pkg::CTRL_RDI_SW];
        // =====================================================
        // REI: error counts accumulate until the next G1 leaves
        rei_wide = {1'b0, st_reg.rei_acc} + {1'b0, rx_b3_err_cnt};
        rei_sum = (rei_wide > {1'b0, spo_pkg::REI_MAX}) ? spo_pkg::REI_MAX : rei_wide[3:0];
        if (st_reg.ctrl[spo_pkg::CTRL_REI_SW]) begin
            rei_field = 4'h1;
        end else if (st_reg.ctrl[spo_pkg::CTRL_REI_AUTO]) begin
            rei_field = st_reg.rei_acc;
        end else begin
            rei_field = 4'h0;
        end
        // =====================================================
        // SPE assembly, one byte per slot requested by the overhead side
        last_byte = (st_reg.row == spo_pkg::SPE_ROWS - 4'h1) &&
                    (st_reg.col == spo_pkg::SPE_COLS - 9'h1);
        unique case (st_reg.ctrl[3:2])
            spo_pkg::TLEN_1: trace_wrap = 6'h00;
            spo_pkg::TLEN_16: trace_wrap = 6'h0f;
            default: trace_wrap = 6'h3f;
        endcase
        pop = 1'b0;
        byte_out = 8'h00;
        if (st_reg.col == 9'h0) begin
            unique case (st_reg.row)
                spo_pkg::ROW_J1: byte_out = st_reg.trace[st_reg.trace_idx];
                spo_pkg::ROW_B3: byte_out = st_reg.b3_hold ^ st_reg.b3_mask;
                spo_pkg::ROW_C2: byte_out = st_reg.c2;
                spo_pkg::ROW_G1: byte_out = {rei_field, st_reg.rdi_tx, st_reg.g1_spare};
                spo_pkg::ROW_F2: byte_out = st_reg.f2;
                spo_pkg::ROW_H4: byte_out = st_reg.h4;
                spo_pkg::ROW_Z3: byte_out = st_reg.z3;
                spo_pkg::ROW_Z4: byte_out = st_reg.z4;
                default: byte_out = st_reg.z5;
            endcase
        end else if (st_reg.hold_cnt != 2'h0 && !ais) begin
            byte_out = st_reg.hold[0];
            pop = spe_req;
        end else begin
            // an empty buffer sends fill; cell sources must keep cells whole
            byte_out = atm ? spo_pkg::FILL_ATM : spo_pkg::FILL_PKT;
        end
        if (ais) begin
            byte_out = spo_pkg::ALL_ONES;
        end
        st_next.out.valid = spe_req;
        st_next.out.poh = spe_req && st_reg.col == 9'h0;
        st_next.out.first = spe_req && st_reg.col == 9'h0 && st_reg.row == spo_pkg::ROW_J1;
        st_next.out.data = spe_req ? byte_out : st_reg.out.data;
        st_next.ptr.inc = 1'b0;
        st_next.ptr.dec = 1'b0;
        st_next.ptr.ndf = st_reg.ctrl[spo_pkg::CTRL_NDF_CONT];
        st_next.ptr.ais = ais;
        if (rx_b3_err_vld) begin
            st_next.rei_acc = rei_sum;
        end
        if (spe_req) begin
            st_next.bip_acc = st_reg.bip_acc ^ byte_out;
            if (st_reg.col == 9'h0 && st_reg.row == spo_pkg::ROW_G1) begin
                // errors arriving with the G1 slot belong to the next report
                st_next.rei_acc = rx_b3_err_vld ? rx_b3_err_cnt : 4'h0;
            end
            if (st_reg.col == 9'h0 && st_reg.row == spo_pkg::ROW_J1) begin
                st_next.trace_idx = (st_reg.trace_idx >= trace_wrap) ? 6'h00
                                    : st_reg.trace_idx + 6'h01;
                st_next.ptr.inc = st_reg.inc_pend;
                st_next.ptr.dec = st_reg.dec_pend && !st_reg.inc_pend;
                st_next.ptr.ndf = st_reg.ptr.ndf || st_reg.ndf_pend ||
                                  st_reg.ctrl[spo_pkg::CTRL_NDF_CONT];
                st_next.inc_pend = 1'b0;
                st_next.dec_pend = st_reg.dec_pend && st_reg.inc_pend;
                st_next.ndf_pend = 1'b0;
            end
            if (last_byte) begin
                st_next.b3_hold = st_reg.bip_acc ^ byte_out;
                st_next.bip_acc = 8'h00;
            end
            if (st_reg.col == spo_pkg::SPE_COLS - 9'h1) begin
                st_next.col = 9'h0;
                st_next.row = (st_reg.row == spo_pkg::SPE_ROWS - 4'h1) ? 4'h0
                              : st_reg.row + 4'h1;
            end else begin
                st_next.col = st_reg.col + 9'h1;
            end
        end
        // command bits set after the delivery clear so a late write is kept
        if (apb_wr && paddr == spo_pkg::OFS_CMD) begin
            if (pwdata[spo_pkg::CMD_INC]) begin
                st_next.inc_pend = 1'b1;
            end
            if (pwdata[spo_pkg::CMD_DEC]) begin
                st_next.dec_pend = 1'b1;
            end
            if (pwdata[spo_pkg::CMD_NDF]) begin
                st_next.ndf_pend = 1'b1;
            end
        end
        // =====================================================
        // two-byte skid buffer so a registered ready still streams
        // a ready already granted is honoured even if the mode changed under it
        push = (cell_valid && st_reg.cell_ready) || (pkt_valid && st_reg.pkt_ready);
        src_data = st_reg.cell_ready ? cell_data : pkt_data;
        cnt_after_pop = st_reg.hold_cnt - {1'b0, pop};
        if (pop) begin
            st_next.hold[0] = st_reg.hold[1];
        end
        if (push) begin
            st_next.hold[cnt_after_pop[0]] = src_data;
        end
        st_next.hold_cnt = cnt_after_pop + {1'b0, push};
        st_next.cell_ready = atm && !ais && st_next.hold_cnt <= 2'h1;
        st_next.pkt_ready = !atm && !ais && st_next.hold_cnt <= 2'h1;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
            st_reg.ctrl <= spo_pkg::CTRL_RESET;
            st_reg.ptr.ais <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign prdata = st_reg.prdata;
    assign pready = st_reg.pready;
    assign pslverr = st_reg.pslverr;
    assign cell_ready = st_reg.cell_ready;
    assign pkt_ready = st_reg.pkt_ready;
    assign spe_out = st_reg.out;
    assign ptr_ctl = st_reg.ptr;
endmodule

/* sim/spo_props.sv */
`timescale 1ns/1ps
module spo_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic cell_ready,
    input wire logic pkt_ready,
    input wire logic spe_req,
    input wire spo_pkg::spo_spe_out_t spe_out,
    input wire spo_pkg::spo_ptr_ctl_t ptr_ctl
);
    // =====================================================
    // slot tracker, counts every byte handed downstream
    logic [11:0] slot_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slot_reg <= 12'h000;
        end else if (spe_out.valid) begin
            slot_reg <= (slot_reg == 12'h92c) ? 12'h000 : slot_reg + 12'h001;
        end
    end
    // =====================================================
    // properties
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_req_valid: assert property (spe_out.valid == $past(spe_req))
        else $error("spe byte does not follow its request");
    a_slot_map: assert property (spe_out.valid |-> (spe_out.first == (slot_reg == 12'h000))
        && (spe_out.poh == (slot_reg % 12'h105 == 12'h000))) else $error("overhead slot misplaced");
    a_stuff_at_j1: assert property ((ptr_ctl.inc || ptr_ctl.dec) |-> spe_out.first)
        else $error("stuff outside the trace slot");
    a_stuff_pulse: assert property (ptr_ctl.inc |=> !ptr_ctl.inc)
        else $error("stuff pulse too long");
    a_ais_quiet: assert property (ptr_ctl.ais [*2] |-> !cell_ready && !pkt_ready)
        else $error("traffic taken during ais");
    a_ais_ones: assert property ((ptr_ctl.ais [*3]) ##0 spe_out.valid |-> spe_out.data == 8'hff)
        else $error("ais byte not all ones");
    a_one_source: assert property (!(cell_ready && pkt_ready))
        else $error("both sources ready");
    a_apb_wait: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
        else $error("apb wait state wrong");
    a_err_with_rdy: assert property (pslverr |-> pready)
        else $error("error without ready");
    c_stuff: cover property (ptr_ctl.inc);
    c_err: cover property (pslverr);
    c_ais_off: cover property (ptr_ctl.ais ##1 !ptr_ctl.ais);
endmodule

/* sim/spo_toh_model.sv */
`timescale 1ns/1ps
module spo_toh_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic slow,
    input wire spo_pkg::spo_spe_out_t spe_out,
    output logic spe_req,
    output logic fdone,
    output logic [8:0][7:0] poh,
    output logic [7:0] b3_exp,
    output int pay_n,
    output int pay_bad
);
    int s;
    logic ph;
    logic [7:0] acc, bip, last;
    // slow mode asks for a byte only every other cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {spe_req, ph, fdone, acc, bip, last, b3_exp} <= '0;
            {s, pay_n, pay_bad} <= '0;
            poh <= '0;
        end else begin
            ph <= ~ph;
            spe_req <= !slow || ph;
            fdone <= (spe_out.valid && s == 2348);
            if (spe_out.valid) begin
                s <= (s == 2348) ? 0 : s + 1;
                acc <= (s == 2348) ? 8'h00 : acc ^ spe_out.data;
                if (s == 2348) bip <= acc ^ spe_out.data;
                if (s == 261) b3_exp <= bip;
                if (s % 261 == 0) poh[s / 261] <= spe_out.data;
                // fill and ais bytes are not source bytes
                if (s % 261 != 0 && !(spe_out.data inside {8'h00, 8'h7e, 8'hff})) begin
                    pay_n <= pay_n + 1;
                    if (pay_n > 0 && spe_out.data != last % 8'h7d + 8'h01) pay_bad <= pay_bad + 1;
                    last <= spe_out.data;
                end
            end
        end
    end
endmodule

/* sim/test_sts3c_path_overhead_tx.sv */
`timescale 1ns/1ps
module test_sts3c_path_overhead_tx;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, slow = 0, er;
    logic cell_valid = 1, pkt_valid = 1, rx_b3_err_vld = 0, spe_req, fdone;
    logic cell_ready, pkt_ready, pready, pslverr;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [7:0] src = 8'h01, b3_exp;
    logic [3:0] rx_b3_err_cnt = 4'h0;
    logic [8:0][7:0] poh;
    spo_pkg::spo_defects_t rx_defects = '0;
    spo_pkg::spo_spe_out_t spe_out;
    spo_pkg::spo_ptr_ctl_t ptr_ctl;
    int pay_n, pay_bad, n_mismatch = 0, samples_checked = 0, cyc = 0, n_inc = 0, n_dec = 0, n_ndf = 0;
    spo_path_overhead_tx dut (.cell_data(src), .pkt_data(src), .*);
    spo_toh_model m (.*);
    always #2 pclk = ~pclk;
    // =====================================================
    // sources share one counter so order is checkable downstream
    always @(posedge pclk) begin
        if ((cell_valid && cell_ready) || (pkt_valid && pkt_ready)) src <= (src == 8'h7d) ? 8'h01 : src + 8'h01;
        n_inc += ptr_ctl.inc;
        n_dec += ptr_ctl.dec;
        n_ndf += ptr_ctl.ndf;
        cyc++;
        if (cyc == 95000) begin
            n_mismatch++;
            results();
        end
    end
    // =====================================================
    // helpers
    task chk(input logic [39:0] g, input logic [39:0] e);
        samples_checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 0; penable <= 0;
    endtask
    task wf(input int k);
        repeat (k) @(posedge fdone);
        @(posedge pclk);
    endtask
    task results;
        $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // =====================================================
    // scenarios
    task t_reset;
        apb(0, spo_pkg::OFS_CTRL, 0); chk(rd, {23'h0, spo_pkg::CTRL_RESET});
        apb(0, 12'h020, 0); chk({er, rd}, 33'h100000000);
        wf(2); chk(ptr_ctl.ais, 1); chk(poh[1], 8'hff); chk(pay_n, 0);
        $display("reset test done");
    endtask
    task t_atm;
        apb(1, spo_pkg::OFS_POH_A, 32'h44332211);
        apb(1, spo_pkg::OFS_POH_B, 32'h00066655);
        apb(1, spo_pkg::OFS_TRACE, 32'h5a);
        apb(1, spo_pkg::OFS_CTRL, 32'h052); wf(2);
        chk(poh[0], 8'h5a); chk(poh[2], 8'h11); chk(poh[3], 8'h06);
        for (int i = 4; i < 9; i++) chk(poh[i], 8'h22 + 8'h11 * (i - 4));
        chk(poh[1], b3_exp);
        chk({pay_n > 100, pay_bad}, 33'h100000000);
        $display("atm test done");
    endtask
    task t_trace;
        apb(1, spo_pkg::OFS_TRACE + 12'h004, 32'ha5);
        apb(1, spo_pkg::OFS_CTRL, 32'h056); wf(2);
        chk(poh[0], 8'h5a);
        wf(1); chk(poh[0], 8'ha5);
        $display("trace test done");
    endtask
    task t_mask;
        apb(1, spo_pkg::OFS_B3MASK, 32'h81); wf(2);
        chk(poh[1], b3_exp ^ 8'h81);
        apb(0, spo_pkg::OFS_B3MASK, 0); chk(rd, 32'h81);
        apb(1, spo_pkg::OFS_B3MASK, 0);
        $display("b3 mask test done");
    endtask
    task t_rdi;
        for (int i = 0; i < 6; i++) begin
            rx_defects <= spo_pkg::spo_defects_t'(6'h01 << i); wf(1);
            chk(poh[3][3], 1);
        end
        rx_defects <= '0; wf(1); chk(poh[3][3], 0);
        apb(1, spo_pkg::OFS_CTRL, 32'h022); wf(1); chk(poh[3][3], 1);
        apb(0, spo_pkg::OFS_STATUS, 0); chk(rd[0], 1);
        $display("rdi test done");
    endtask
    task t_rei;
        apb(1, spo_pkg::OFS_CTRL, 32'h052); wf(1);
        rx_b3_err_vld <= 1; rx_b3_err_cnt <= 4'h3;
        @(posedge pclk) rx_b3_err_cnt <= 4'h7;
        @(posedge pclk) rx_b3_err_vld <= 0;
        wf(1); chk(poh[3][7:4], 4'h8);
        slow <= 1; apb(1, spo_pkg::OFS_CTRL, 32'h092); wf(2);
        chk(poh[3][7:4], 4'h1); slow <= 0;
        $display("rei test done");
    endtask
    task t_stuff;
        int a, b, c;
        a = n_inc; b = n_dec; c = n_ndf;
        apb(1, spo_pkg::OFS_CMD, 32'h7); wf(3);
        chk(n_inc - a, 1); chk(n_dec - b, 1); chk(n_ndf - c, 1);
        apb(0, spo_pkg::OFS_CMD, 0); chk(rd, 0);
        apb(1, spo_pkg::OFS_CTRL, 32'h152); wf(1); chk(ptr_ctl.ndf, 1);
        $display("pointer test done");
    endtask
    task t_pkt;
        int p;
        apb(1, spo_pkg::OFS_CTRL, 32'h050); wf(2);
        p = pay_n; wf(1);
        chk({pay_n > p, pay_bad, cell_ready}, 34'h200000000);
        $display("packet test done");
    endtask
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1;
        t_reset(); t_atm(); t_trace(); t_mask(); t_rdi(); t_rei(); t_stuff(); t_pkt();
        results();
    end
endmodule
bind spo_path_overhead_tx spo_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pready(pready), .pslverr(pslverr), .cell_ready(cell_ready),
    .pkt_ready(pkt_ready), .spe_req(spe_req), .spe_out(spe_out), .ptr_ctl(ptr_ctl));
